// file: rtl/cbd_defs.svh
// cbd_defs.svh: decode values, register offsets and timing figures of the console bus block
// assumes: included by the package and by the design file, by its bare name
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH
`define CBD_ABUS_W 11
`define CBD_DBUS_W 8
// region code, address bits 15:11
`define CBD_RGN_RAM 5'h00
`define CBD_RGN_IO 5'h01
`define CBD_RGN_ROM 5'h1F
// i/o offsets, address bits 2:0
`define CBD_IO_LED0 3'h0
`define CBD_IO_LED1 3'h1
`define CBD_IO_BEEP 3'h2
`define CBD_IO_KEY 3'h3
`define CBD_IO_SER_TX 3'h4
`define CBD_IO_SER_RX 3'h5
`define CBD_IO_SER_ST 3'h6
`define CBD_DISP_BASE 11'h7E0
`define CBD_DISP_LEN 16
`define CBD_KEY_COLS 9
`define CBD_KEY_ROWS 4
`define CBD_FIFO_DEPTH 32
`define CBD_CHAR_RST 16'h8000
`define CBD_COL_RST 9'h001
`define CBD_MEM_RST {11'h000, 4'hF}
// timing, in ns, and derived cycle counts
`define CBD_CLK_NS 10
`define CBD_SCAN_NS 1000000
`define CBD_REFR_NS 100000
`define CBD_TONE_NS 250000
`define CBD_SER_NS 10000
`define CBD_SCAN_CYC (`CBD_SCAN_NS / `CBD_CLK_NS)
`define CBD_REFR_CYC (`CBD_REFR_NS / `CBD_CLK_NS)
`define CBD_TONE_CYC (`CBD_TONE_NS / `CBD_CLK_NS)
`define CBD_SER_CYC (`CBD_SER_NS / `CBD_CLK_NS)
`endif

// file: rtl/cbd_pkg.sv
// cbd_pkg: bus carriers and serial state type of the console bus block
// assumes: cbd_defs.svh on the include path
`include "cbd_defs.svh"
package cbd_pkg;
  // processor multiplexed port as seen by the block
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] ahi;
    logic [`CBD_DBUS_W-1:0] ad;
  } cbd_cpu_t;
  // shared memory bus controls
  typedef struct packed {
    logic [`CBD_ABUS_W-1:0] addr;
    logic ram_cs_n;
    logic rom_oe_n;
    logic rd_n;
    logic wr_n;
  } cbd_mem_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LOW = 2'b01,
    SER_HIGH = 2'b10
  } cbd_ser_t;
endpackage

// file: rtl/cbd_top.sv
// cbd_top: console bus controller, memory manager, display fetch, keys, beeper, serial link
// assumes: processor port synchronous to core_clk; key rows and serial input are raw pins
`timescale 1ns/1ps
`include "cbd_defs.svh"

// ==========================================================
// fifo between display fetch and segment loading
module cbd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `CBD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;
  assign in_ready = (wp_q - rp_q) != (AW + 1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem_q[rp_q[AW-1:0]];
  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_d = wp_q + (AW + 1)'(push);
    rp_d = rp_q + (AW + 1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule // cbd_fifo

// ==========================================================
// top
module cbd_top import cbd_pkg::*; #(
  parameter int SCAN_CYC = `CBD_SCAN_CYC,
  parameter int REFR_CYC = `CBD_REFR_CYC,
  parameter int TONE_CYC = `CBD_TONE_CYC,
  parameter int SER_CYC = `CBD_SER_CYC,
  parameter int DISP_LEN = `CBD_DISP_LEN,
  parameter int FIFO_DEPTH = `CBD_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire cbd_cpu_t cpu_i,
  output logic [7:0] cpu_ad_o,
  output logic cpu_ad_oe_n,
  output cbd_mem_t mem_o,
  input wire logic [7:0] mem_d_i,
  output logic [7:0] mem_d_o,
  output logic mem_d_oe_n,
  output logic buf_to_cpu,
  output logic cpu_owns_bus,
  output logic led_stb,
  output logic [15:0] led,
  output logic [7:0] seg,
  output logic seg_load,
  output logic [DISP_LEN-1:0] char_pos,
  output logic beep,
  output logic [`CBD_KEY_COLS-1:0] key_col,
  input wire logic [`CBD_KEY_ROWS-1:0] key_row_i,
  input wire logic ser_rx_i,
  output logic ser_clk_o,
  output logic ser_tx_o
);
  localparam int PW = $clog2(DISP_LEN);
  localparam int NDIV = 4;
  localparam int D_SCAN = 0;
  localparam int D_REFR = 1;
  localparam int D_TONE = 2;
  localparam int D_SER = 3;
  localparam int DIV_LIM [NDIV] = '{SCAN_CYC, REFR_CYC, TONE_CYC, SER_CYC};

  function automatic logic [3:0] col_index(input logic [`CBD_KEY_COLS-1:0] oh);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < `CBD_KEY_COLS; i++) begin
      if (oh[i]) idx = 4'(i);
    end
    return idx;
  endfunction

  // ==========================================================
  // reset release
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // rate dividers
  logic [23:0] div_q [NDIV];
  logic [23:0] div_d [NDIV];
  logic tick [NDIV];
  for (genvar g = 0; g < NDIV; g++) begin : g_div
    assign tick[g] = div_q[g] == 24'(DIV_LIM[g] - 1);
    always_comb begin
      div_d[g] = tick[g] ? 24'h000000 : div_q[g] + 24'h000001;
    end
    always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) div_q[g] <= 24'h000000;
      else div_q[g] <= div_d[g];
    end
  end

  // ==========================================================
  // pin synchronisers: rows in 3:0, serial input in 4
  logic [4:0] s1_q, s2_q, s3_q, pin_f_q, pin_f_d;
  always_comb begin
    pin_f_d = (s2_q & s3_q) | (pin_f_q & (s2_q ^ s3_q));
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      pin_f_q <= 5'h00;
    end else begin
      s1_q <= {ser_rx_i, key_row_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  // ==========================================================
  // bus controller and memory manager
  logic [7:0] alo_q, alo_d, io_rdata, mem_d_o_d, cpu_ad_o_d;
  logic [PW-1:0] dptr_q, dptr_d;
  logic [15:0] addr16;
  logic [10:0] cpu_addr;
  logic [2:0] sub;
  logic dma_pend_q, dma_pend_d, wr_prev_q, rd_prev_q;
  logic cpu_rd, cpu_wr, hit_ram, hit_rom, hit_io, io_wr, rx_take, dma_go;
  logic cpu_ad_oe_n_d, mem_d_oe_n_d, buf_to_cpu_d, owns_d;
  logic f_in_ready, f_out_valid, f_pop;
  logic [7:0] f_out_data;
  cbd_mem_t mem_d;
  assign addr16 = {cpu_i.ahi, alo_q};
  assign cpu_addr = addr16[10:0];
  always_comb begin
    cpu_rd = !cpu_i.rd_n;
    cpu_wr = !cpu_i.wr_n;
    sub = addr16[2:0];
    hit_ram = addr16[15:11] == `CBD_RGN_RAM;
    hit_io = addr16[15:11] == `CBD_RGN_IO;
    hit_rom = addr16[15:11] == `CBD_RGN_ROM;
    io_wr = cpu_wr & !wr_prev_q & hit_io;
    rx_take = cpu_rd & !rd_prev_q & hit_io & (sub == `CBD_IO_SER_RX);
    alo_d = cpu_i.ale ? cpu_i.ad : alo_q;
    dma_go = !cpu_i.ale & !cpu_rd & !cpu_wr & !dma_pend_q & f_in_ready;
    dma_pend_d = dma_go;
    dptr_d = dma_go ? dptr_q + PW'(1) : dptr_q;
    owns_d = cpu_i.ale | cpu_rd | cpu_wr;
    mem_d.addr = cpu_addr;
    mem_d.ram_cs_n = !((cpu_rd | cpu_wr) & hit_ram);
    mem_d.rom_oe_n = !(cpu_rd & !cpu_wr & hit_rom);
    mem_d.rd_n = !cpu_rd;
    mem_d.wr_n = !cpu_wr;
    if (dma_go) begin
      mem_d.addr = `CBD_DISP_BASE + 11'(dptr_q);
      mem_d.ram_cs_n = 1'b0;
      mem_d.rd_n = 1'b0;
    end
    buf_to_cpu_d = cpu_rd;
    cpu_ad_oe_n_d = !(cpu_rd & (hit_ram | hit_rom | hit_io));
    cpu_ad_o_d = hit_io ? io_rdata : mem_d_i;
    mem_d_oe_n_d = !cpu_wr;
    mem_d_o_d = cpu_i.ad;
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alo_q <= 8'h00;
      dptr_q <= '0;
      dma_pend_q <= 1'b0;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      mem_o <= `CBD_MEM_RST;
      cpu_owns_bus <= 1'b0;
      buf_to_cpu <= 1'b0;
      cpu_ad_oe_n <= 1'b1;
      cpu_ad_o <= 8'h00;
      mem_d_oe_n <= 1'b1;
      mem_d_o <= 8'h00;
    end else begin
      alo_q <= alo_d;
      dptr_q <= dptr_d;
      dma_pend_q <= dma_pend_d;
      wr_prev_q <= cpu_wr;
      rd_prev_q <= cpu_rd;
      mem_o <= mem_d;
      cpu_owns_bus <= owns_d;
      buf_to_cpu <= buf_to_cpu_d;
      cpu_ad_oe_n <= cpu_ad_oe_n_d;
      cpu_ad_o <= cpu_ad_o_d;
      mem_d_oe_n <= mem_d_oe_n_d;
      mem_d_o <= mem_d_o_d;
    end
  end

  // ==========================================================
  // display fetch and drive
  cbd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .in_data(mem_d_i),
    .in_valid(dma_pend_q),
    .in_ready(f_in_ready),
    .out_data(f_out_data),
    .out_valid(f_out_valid),
    .out_ready(tick[D_REFR])
  );
  logic [7:0] seg_d;
  logic seg_load_d;
  logic [DISP_LEN-1:0] char_d;
  always_comb begin
    f_pop = tick[D_REFR] & f_out_valid;
    seg_d = f_pop ? f_out_data : seg;
    seg_load_d = f_pop;
    char_d = f_pop ? {char_pos[DISP_LEN-2:0], char_pos[DISP_LEN-1]} : char_pos;
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seg <= 8'h00;
      seg_load <= 1'b0;
      char_pos <= DISP_LEN'(`CBD_CHAR_RST >> (16 - DISP_LEN));
    end else begin
      seg <= seg_d;
      seg_load <= seg_load_d;
      char_pos <= char_d;
    end
  end

  // ==========================================================
  // leds, keys, beeper, serial link
  logic [15:0] led_d;
  logic [`CBD_KEY_COLS-1:0] col_d;
  logic [7:0] beep_cnt_q, beep_cnt_d, sh_q, sh_d, rx_sh_q, rx_sh_d, rx_buf_q, rx_buf_d;
  logic [3:0] bit_q, bit_d;
  logic led_stb_d, beep_d, rx_full_q, rx_full_d, rx_set, ser_clk_d, ser_tx_d;
  cbd_ser_t ser_st_q, ser_st_d;
  always_comb begin
    if (sub == `CBD_IO_KEY) io_rdata = {col_index(key_col), pin_f_q[3:0]};
    else if (sub == `CBD_IO_SER_RX) io_rdata = rx_buf_q;
    else if (sub == `CBD_IO_SER_ST) io_rdata = {6'h00, rx_full_q, ser_st_q != SER_IDLE};
    else io_rdata = 8'h00;
  end
  always_comb begin
    led_d = led;
    led_stb_d = io_wr & ((sub == `CBD_IO_LED0) | (sub == `CBD_IO_LED1));
    if (io_wr && sub == `CBD_IO_LED0) led_d[7:0] = cpu_i.ad;
    if (io_wr && sub == `CBD_IO_LED1) led_d[15:8] = cpu_i.ad;
    col_d = tick[D_SCAN] ? {key_col[`CBD_KEY_COLS-2:0], key_col[`CBD_KEY_COLS-1]} : key_col;
    beep_cnt_d = beep_cnt_q;
    beep_d = beep;
    if (tick[D_TONE] && beep_cnt_q != 8'h00) begin
      beep_cnt_d = beep_cnt_q - 8'h01;
      beep_d = !beep;
    end
    if (beep_cnt_q == 8'h00) beep_d = 1'b0;
    if (io_wr && sub == `CBD_IO_BEEP) beep_cnt_d = cpu_i.ad;
  end
  always_comb begin
    ser_st_d = ser_st_q;
    sh_d = sh_q;
    rx_sh_d = rx_sh_q;
    rx_buf_d = rx_buf_q;
    bit_d = bit_q;
    ser_clk_d = ser_clk_o;
    rx_set = 1'b0;
    case (ser_st_q)
      SER_IDLE: begin
        ser_clk_d = 1'b1;
        if (io_wr && sub == `CBD_IO_SER_TX) begin
          sh_d = cpu_i.ad;
          bit_d = 4'h8;
          ser_clk_d = 1'b0;
          ser_st_d = SER_LOW;
        end
      end
      SER_LOW: begin
        if (tick[D_SER]) begin
          ser_clk_d = 1'b1;
          ser_st_d = SER_HIGH;
        end
      end
      SER_HIGH: begin
        if (tick[D_SER]) begin
          // sample at the end of the bit: the input filter lags several cycles
          rx_sh_d = {rx_sh_q[6:0], pin_f_q[4]};
          sh_d = {sh_q[6:0], 1'b0};
          bit_d = bit_q - 4'h1;
          ser_clk_d = 1'b0;
          ser_st_d = SER_LOW;
          if (bit_q == 4'h1) begin
            ser_clk_d = 1'b1;
            ser_st_d = SER_IDLE;
            rx_buf_d = {rx_sh_q[6:0], pin_f_q[4]};
            rx_set = 1'b1;
          end
        end
      end
      default: ser_st_d = SER_IDLE;
    endcase
    ser_tx_d = sh_d[7];
    rx_full_d = rx_set | (rx_full_q & !rx_take);
  end
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      led <= 16'h0000;
      led_stb <= 1'b0;
      key_col <= `CBD_COL_RST;
      beep_cnt_q <= 8'h00;
      beep <= 1'b0;
      ser_st_q <= SER_IDLE;
      sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      bit_q <= 4'h0;
      ser_clk_o <= 1'b1;
      ser_tx_o <= 1'b0;
    end else begin
      led <= led_d;
      led_stb <= led_stb_d;
      key_col <= col_d;
      beep_cnt_q <= beep_cnt_d;
      beep <= beep_d;
      ser_st_q <= ser_st_d;
      sh_q <= sh_d;
      rx_sh_q <= rx_sh_d;
      rx_buf_q <= rx_buf_d;
      rx_full_q <= rx_full_d;
      bit_q <= bit_d;
      ser_clk_o <= ser_clk_d;
      ser_tx_o <= ser_tx_d;
    end
  end

  // ==========================================================
  // checks
  a_addr_latch: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (cpu_rd || cpu_wr) |=> mem_o.addr == $past(cpu_addr)) else $error("address not latched");
  a_ram_select: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    ((cpu_rd || cpu_wr) && hit_ram) |=> !mem_o.ram_cs_n) else $error("ram not selected");
  a_rom_no_write: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !mem_o.rom_oe_n |-> $past(cpu_rd && !cpu_wr && hit_rom)) else $error("rom enabled wrongly");
  a_led_strobe: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (io_wr && sub == `CBD_IO_LED0) |=> led_stb && led[7:0] == $past(cpu_i.ad))
    else $error("led latch missed");
  a_led_hold: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !led_stb |-> led == $past(led)) else $error("led changed unstrobed");
  a_buf_dir: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    cpu_rd ##1 cpu_rd |-> buf_to_cpu && mem_d_oe_n) else $error("buffer direction wrong");
  a_owner_flag: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    cpu_owns_bus == $past(cpu_i.ale || !cpu_i.rd_n || !cpu_i.wr_n)) else $error("owner flag wrong");
  a_dma_idle: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    dma_pend_q |-> !cpu_owns_bus && mem_o.addr == `CBD_DISP_BASE + 11'($past(dptr_q)))
    else $error("fetch in busy cycle");
  a_char_step: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    seg_load |-> $onehot(char_pos) && char_pos != $past(char_pos)) else $error("position stuck");
  a_seg_load: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !seg_load |-> $stable(seg)) else $error("segments changed unloaded");
  a_beep_quiet: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (beep_cnt_q == 8'h00) |=> !beep) else $error("beep without count");
  a_ser_frame: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (io_wr && sub == `CBD_IO_SER_TX && ser_st_q == SER_IDLE) |=>
    !ser_clk_o && ser_tx_o == $past(cpu_i.ad[7])) else $error("serial frame start wrong");
  a_col_scan: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    $onehot(key_col) and (!tick[D_SCAN] |=> $stable(key_col))) else $error("column scan wrong");
  a_key_read: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    sub == `CBD_IO_KEY |-> io_rdata[7:4] == col_index(key_col)) else $error("key column index");
  a_regions: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    $onehot0({!mem_o.rom_oe_n, led_stb, !mem_o.ram_cs_n && !dma_pend_q}))
    else $error("regions overlap");
endmodule // cbd_top

// file: verif/cbd_mem_model.sv
// cbd_mem_model: shared ram and rom behind the memory bus of the console bus block
// assumes: mem_o of cbd_top drives it; its read data returns combinationally
`timescale 1ns/1ps
// ==========================================================
// memory
module cbd_mem_model import cbd_pkg::*; (
  input wire logic core_clk,
  input wire cbd_mem_t mem_i,
  input wire logic [7:0] wdata,
  input wire logic wdata_oe_n,
  output logic [7:0] rdata
);
  logic [7:0] ram [0:2047];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 2048; i++) ram[i] = 8'h00;
    last_q = 8'h00;
  end
  // 2k ram and 2k rom; released bus shows a changing pattern
  always_comb begin
    if (!mem_i.ram_cs_n && !mem_i.rd_n) rdata = ram[mem_i.addr];
    else if (!mem_i.rom_oe_n) rdata = mem_i.addr[7:0] ^ {5'h00, mem_i.addr[10:8]} ^ 8'hA5;
    else rdata = ~last_q;
  end
  always @(posedge core_clk) begin
    last_q <= rdata;
    if (!mem_i.ram_cs_n && !mem_i.wr_n && !wdata_oe_n) ram[mem_i.addr] <= wdata;
  end
endmodule // cbd_mem_model

// file: verif/test_console_bus_display_dma.sv
// test_console_bus_display_dma: self-checking bench of cbd_top with a memory model
// assumes: short parameter values for scan, refresh, tone and serial counts
`timescale 1ns/1ps
module test_console_bus_display_dma import cbd_pkg::*;;
  localparam int TC = 4;
  logic core_clk, arst_n;
  cbd_cpu_t cpu;
  cbd_mem_t mem_o;
  logic [7:0] cpu_ad_o, mem_d_i, mem_d_o, seg, q;
  logic cpu_ad_oe_n, mem_d_oe_n, buf_to_cpu, cpu_owns_bus, led_stb, seg_load, beep;
  logic ser_clk_o, ser_tx_o, chk_disp, sclk_l, beep_l;
  logic [15:0] led, char_pos;
  logic [8:0] key_col, col_l;
  logic [3:0] key_row;
  logic [7:0] bram [0:2047];
  logic [7:0] sh, d;
  logic [10:0] al [$];
  int fail_count, n_compared, kload, nstb, ntog, nfetch, cyc_n;
  // ==========================================================
  // design and memory
  cbd_top #(.SCAN_CYC(8), .REFR_CYC(4), .TONE_CYC(TC), .SER_CYC(6)) cbd_top_i (
    .core_clk(core_clk), .arst_n(arst_n), .cpu_i(cpu), .cpu_ad_o(cpu_ad_o),
    .cpu_ad_oe_n(cpu_ad_oe_n), .mem_o(mem_o), .mem_d_i(mem_d_i), .mem_d_o(mem_d_o),
    .mem_d_oe_n(mem_d_oe_n), .buf_to_cpu(buf_to_cpu), .cpu_owns_bus(cpu_owns_bus),
    .led_stb(led_stb), .led(led), .seg(seg), .seg_load(seg_load), .char_pos(char_pos),
    .beep(beep), .key_col(key_col), .key_row_i(key_row), .ser_rx_i(ser_tx_o),
    .ser_clk_o(ser_clk_o), .ser_tx_o(ser_tx_o));
  cbd_mem_model cbd_mem_model_i (.core_clk(core_clk), .mem_i(mem_o), .wdata(mem_d_o),
    .wdata_oe_n(mem_d_oe_n), .rdata(mem_d_i));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================
  // compare and bus tasks
  task automatic chk_b(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [7:0] rom_b(input logic [10:0] a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'hA5;
  endfunction
  task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] dd,
    output logic [7:0] qq);
    logic mapped;
    mapped = a[15:11] == 5'h00 || a[15:11] == 5'h01 || a[15:11] == 5'h1F;
    @(posedge core_clk);
    #1;
    cpu.ale = 1'b1;
    cpu.ahi = a[15:8];
    cpu.ad = a[7:0];
    @(posedge core_clk);
    #1;
    cpu.ale = 1'b0;
    cpu.ad = wr ? dd : ~a[7:0];
    cpu.rd_n = wr;
    cpu.wr_n = ~wr;
    @(posedge core_clk);
    #1;
    chk_b(buf_to_cpu, ~wr, "direction");
    chk_b(cpu_owns_bus, 1'b1, "owner");
    chk_b(mem_o.ram_cs_n, a[15:11] != 5'h00, "ram select");
    chk_b(mem_o.rom_oe_n, wr || a[15:11] != 5'h1F, "rom enable");
    chk_v(mem_o.addr, a[10:0], "address");
    if (!wr) chk_b(cpu_ad_oe_n, !mapped, "cpu drive");
    @(posedge core_clk);
    #1;
    qq = cpu_ad_o;
    cpu.rd_n = 1'b1;
    cpu.wr_n = 1'b1;
  endtask
  // ==========================================================
  // monitors
  // sampled on the falling edge, where design outputs have settled
  always @(negedge core_clk) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      fail_count++;
      end_sim();
    end
    if (arst_n) begin
      if (led_stb) nstb++;
      if (beep !== beep_l) ntog++;
      if (key_col !== col_l) chk_v(key_col, {col_l[7:0], col_l[8]}, "column");
      if (ser_clk_o && !sclk_l) sh = {sh[6:0], ser_tx_o};
      if (seg_load) begin
        chk_v(char_pos, 16'h0001 << (kload % 16), "position");
        if (chk_disp) chk_v(seg, bram[11'h7E0 + kload % 16], "segments");
        kload++;
      end
      if (chk_disp && !mem_o.ram_cs_n) begin
        nfetch++;
        chk_v(mem_o.addr[10:4], 7'h7E, "fetch address");
        chk_b(cpu_owns_bus, 1'b0, "fetch owner");
      end
    end
    beep_l <= beep;
    col_l <= key_col;
    sclk_l <= ser_clk_o;
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h99EB1E22));
    cpu = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ahi: 8'h00, ad: 8'h00};
    key_row = 4'h0;
    arst_n = 1'b0;
    chk_disp = 1'b0;
    for (int i = 0; i < 2048; i++) bram[i] = 8'h00;
    repeat (12) @(posedge core_clk);
    chk_v(char_pos, 16'h8000, "reset position");
    chk_v(led, 16'h0000, "reset leds");
    chk_v(key_col, 16'h0001, "reset columns");
    chk_v({mem_o.ram_cs_n, mem_o.rom_oe_n, cpu_ad_oe_n, ser_clk_o}, 4'hF, "reset bus");
    #1 arst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    // ram write and read back, back to back, boundaries included
    al.push_back(11'h000);
    al.push_back(11'h7FF);
    for (int i = 0; i < 20; i++) al.push_back($urandom_range(11'h7DF));
    foreach (al[i]) begin
      d = $urandom;
      cyc({5'h00, al[i]}, 1'b1, d, q);
      bram[al[i]] = d;
    end
    foreach (al[i]) begin
      cyc({5'h00, al[i]}, 1'b0, 8'h00, q);
      chk_v(q, bram[al[i]], "ram read");
    end
    // rom read, rom write, unmapped read
    for (int i = 0; i < 6; i++) begin
      al[0] = (i < 2) ? {11{i[0]}} : $urandom;
      cyc({5'h1F, al[0]}, 1'b0, 8'h00, q);
      chk_v(q, rom_b(al[0]), "rom read");
    end
    cyc(16'hFFFF, 1'b1, 8'h3C, q);
    cyc(16'h4000, 1'b0, 8'h00, q);
    // led latches
    nstb = 0;
    cyc(16'h0800, 1'b1, 8'hA6, q);
    cyc(16'h0801, 1'b1, 8'h59, q);
    chk_v(led, 16'h59A6, "leds");
    chk_v(nstb, 2, "led strobes");
    cyc(16'h0000, 1'b0, 8'h00, q);
    chk_v(q, bram[0], "led aliasing");
    // display data through idle fetch
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      cyc(16'h07E0 + i, 1'b1, d, q);
      bram[11'h7E0 + i] = d;
    end
    repeat (400) @(posedge core_clk);
    chk_disp = 1'b1;
    nfetch = 0;
    repeat (200) @(posedge core_clk);
    chk_disp = 1'b0;
    chk_b(nfetch > 0 && kload > 40, 1'b1, "display activity");
    // beeper
    ntog = 0;
    cyc(16'h0802, 1'b1, 8'h05, q);
    repeat (5 * TC + 20) @(posedge core_clk);
    // five half periods, then the drive drops back to quiet
    chk_v(ntog, 6, "beep toggles");
    chk_b(beep, 1'b0, "beep quiet");
    // keys
    for (int i = 0; i < 4; i++) begin
      key_row = $urandom;
      repeat (10) @(posedge core_clk);
      cyc(16'h0803, 1'b0, 8'h00, q);
      chk_v(q[3:0], key_row, "rows");
      chk_b(q[7:4] < 4'h9, 1'b1, "column index");
    end
    // serial loopback frame
    for (int i = 0; i < 2; i++) begin
      d = $urandom;
      cyc(16'h0804, 1'b1, d, q);
      for (int t = 0; t < 40; t++) begin
        cyc(16'h0806, 1'b0, 8'h00, q);
        if (q[1:0] === 2'b10) break;
      end
      chk_v(q, 8'h02, "serial status");
      chk_v(sh, d, "wire bits");
      chk_b(ser_clk_o, 1'b1, "serial idle");
      cyc(16'h0805, 1'b0, 8'h00, q);
      chk_v(q, d, "serial receive");
    end
    end_sim();
  end
endmodule // test_console_bus_display_dma
